//--- hw/uht_pkg.sv
// constants, register map and types for the usb host transfer sequencer
package uht_pkg;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_REQ = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_EP = 8'h0C;
	localparam logic [7:0] A_WAIT = 8'h10;
	localparam logic [7:0] A_WDOG = 8'h14;
	localparam logic [7:0] A_POLL = 8'h18;
	localparam logic [7:0] A_FIFO = 8'h1C;
	// control register fields
	localparam int B_SOFEN = 0;
	localparam int B_FOREVER = 1;
	localparam int B_TYPE = 2;
	localparam int B_DIRIN = 4;
	localparam int B_EPNUM = 5;
	localparam int B_START = 9;
	// request register fields
	localparam int B_MAXPKT = 16;
	// status register fields
	localparam int B_TICK = 16;
	localparam int B_BUSY = 17;
	localparam int B_CSENT = 18;
	localparam int B_HSPEND = 19;
	localparam int B_OWNED = 20;
	localparam int B_FAILED = 21;
	localparam int B_SCAN = 22;
	// endpoint register fields
	localparam int B_LINK = 1;
	localparam int B_ERR = 8;
	localparam int B_NAKS = 16;
	// fifo register fields
	localparam int B_FVALID = 16;
	// controller event request bits, cleared by a one at the position
	localparam int EV_SOF = 0;
	localparam int EV_OTG = 1;
	localparam int EV_ERR = 2;
	localparam int EV_TRN = 3;
	localparam int EV_W = 4;
	// token pids
	localparam logic [3:0] PID_ACK = 4'h2;
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [3:0] PID_DATA1 = 4'hB;
	localparam logic [3:0] PID_NAK = 4'hA;
	// nak retry limits per transfer type
	localparam logic [15:0] NAK_LIM_INTR = 16'd3;
	localparam logic [15:0] NAK_LIM_CTRL = 16'd200;
	localparam logic [15:0] NAK_LIM_BULK = 16'd20000;
	// error codes left on the endpoint
	localparam logic [7:0] ERR_NAK_LIMIT = 8'hF0;
	localparam logic [3:0] ERR_PID_TAG = 4'h1;
	// reset values
	localparam logic [15:0] RST_CREDIT_INC = 16'h0002;
	localparam logic [10:0] RST_MAXPKT = 11'h040;
	// receive fifo shape
	localparam int FIFO_W = 16;
	localparam int FIFO_D = 16;
	typedef enum logic [1:0] {XT_CTRL, XT_INTR, XT_BULK} uht_xfer_t;
endpackage

//--- hw/uht_seq.sv
// usb host transfer sequencer with receive fifo and apb registers
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns

module uht_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_q, rp_q;
	logic push, pop;
	assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
	assign out_valid = wp_q != rp_q;
	assign out_data = mem[rp_q[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule

module uht_seq
	import uht_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// controller event requests and their write-one clear
	input wire logic [uht_pkg::EV_W-1:0] evt_req,
	output logic [uht_pkg::EV_W-1:0] evt_clr,
	input wire logic ctrl_busy,
	// completion status and descriptors
	input wire logic stat_dir_tx,
	input wire logic [3:0] stat_ep,
	input wire logic bd_tx_own,
	input wire logic [3:0] bd_tx_pid,
	input wire logic [10:0] bd_tx_cnt,
	input wire logic bd_rx_own,
	input wire logic [3:0] bd_rx_pid,
	input wire logic [10:0] bd_rx_cnt,
	// received data stream
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [uht_pkg::FIFO_W-1:0] rx_data,
	// token issue and system reset
	output logic token_go,
	output logic [3:0] scan_ep,
	output logic sys_reset_req
);
	import uht_pkg::*;
	typedef enum {S_IDLE, S_ACK, S_EVAL, S_NEXT} uht_state_t;
	uht_state_t st_q;
	logic sofen_q, forever_q, dirin_q, start_q, stx_q;
	logic [1:0] type_q;
	logic [3:0] epnum_q, scan_q, sep_q, pid;
	logic [10:0] maxpkt_q, cnt;
	logic tickf_q, busy_q, csent_q, hspend_q, owned_q, failed_q, setup_q, link_q, toggle_q;
	logic [7:0] err_q;
	logic [15:0] len_q, fill_q, naks_q, wait_q, wdog_q, inc_q, pool_q;
	logic [15:0] fill_new, naks_new, lim;
	logic [31:0] prdata_q;
	logic tick, wr, rd_setup, rd_acc, hit, f_valid, f_pop;
	logic own, is_ok, short_pkt, full, finish, failnak, nak_retry;
	logic [FIFO_W-1:0] f_data;

	uht_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// tick source follows frame generation
	assign tick = sofen_q ? evt_req[EV_SOF] : evt_req[EV_OTG];

	// apb: zero wait states, read data latched in the setup cycle
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign hit = paddr[1:0] == 2'b00 && paddr <= A_FIFO;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_q;
	assign f_pop = rd_acc & (paddr == A_FIFO);
	assign scan_ep = scan_q;
	assign token_go = (st_q == S_NEXT) | start_q;

	// completion decode on the captured direction
	assign own = stx_q ? bd_tx_own : bd_rx_own;
	assign pid = stx_q ? bd_tx_pid : bd_rx_pid;
	assign cnt = stx_q ? bd_tx_cnt : bd_rx_cnt;
	assign is_ok = pid == PID_ACK || pid == PID_DATA0 || pid == PID_DATA1;
	assign fill_new = fill_q + {5'h00, cnt};
	assign short_pkt = cnt < maxpkt_q;
	assign full = fill_new >= len_q;
	assign naks_new = naks_q + 16'h0001;
	assign lim = type_q == XT_CTRL ? NAK_LIM_CTRL :
		(type_q == XT_INTR ? NAK_LIM_INTR : NAK_LIM_BULK);
	assign failnak = naks_new > lim;
	assign nak_retry = forever_q;

	always_comb begin
		finish = 1'b0;
		if (is_ok) begin
			if (type_q == XT_CTRL) begin
				finish = hspend_q;
			end else begin
				finish = full | short_pkt | (cnt == 11'h000);
			end
		end else if (pid == PID_NAK && !nak_retry) begin
			finish = (type_q == XT_INTR && dirin_q) | failnak;
		end
	end

	// event clears: direct writes of a one per bit, several may coincide, never read-modify-write
	always_comb begin
		evt_clr = '0;
		evt_clr[EV_SOF] = evt_req[EV_SOF];
		evt_clr[EV_OTG] = evt_req[EV_OTG];
		evt_clr[EV_ERR] = st_q == S_IDLE && evt_req[EV_ERR];
		evt_clr[EV_TRN] = st_q == S_ACK;
	end

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= S_IDLE;
			stx_q <= 1'b0;
			sep_q <= '0;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (evt_req[EV_ERR]) begin
						st_q <= S_IDLE;
					end else if (evt_req[EV_TRN]) begin
						stx_q <= stat_dir_tx;
						sep_q <= stat_ep;
						st_q <= S_ACK;
					end
				end
				S_ACK: st_q <= S_EVAL;
				S_EVAL: st_q <= (own || sep_q != epnum_q) ? S_IDLE : S_NEXT;
				S_NEXT: st_q <= S_IDLE;
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// request and endpoint state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_q <= '0;
			hspend_q <= 1'b0;
			owned_q <= 1'b0;
			failed_q <= 1'b0;
			setup_q <= 1'b0;
			link_q <= 1'b0;
			toggle_q <= 1'b0;
			err_q <= '0;
			naks_q <= '0;
		end else if (start_q) begin
			fill_q <= '0;
			hspend_q <= 1'b0;
			owned_q <= 1'b1;
			failed_q <= 1'b0;
			setup_q <= type_q == XT_CTRL;
			link_q <= 1'b1;
			naks_q <= '0;
		end else if (wr && paddr == A_EP) begin
			toggle_q <= pwdata[0];
			err_q <= pwdata[B_ERR+:8];
		end else if (st_q == S_EVAL && !own && sep_q == epnum_q) begin
			if (is_ok) begin
				toggle_q <= ~toggle_q;
				fill_q <= fill_new;
				setup_q <= 1'b0;
				if (type_q == XT_CTRL && !hspend_q && (full || (short_pkt && !setup_q))) begin
					hspend_q <= 1'b1;
				end
			end else if (pid == PID_NAK) begin
				if (!nak_retry) begin
					naks_q <= naks_new;
					if (failnak && !(type_q == XT_INTR && dirin_q)) begin
						failed_q <= 1'b1;
						err_q <= ERR_NAK_LIMIT;
					end
				end
			end else begin
				err_q <= {ERR_PID_TAG, pid};
				failed_q <= 1'b1;
				owned_q <= 1'b0;
			end
			if (finish) begin
				link_q <= 1'b0;
				owned_q <= 1'b0;
			end
		end
	end

	// per-millisecond housekeeping and scan pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tickf_q <= 1'b0;
			csent_q <= 1'b0;
			scan_q <= '0;
			wait_q <= '0;
			wdog_q <= '0;
			pool_q <= '0;
			sys_reset_req <= 1'b0;
		end else begin
			if (tick) begin
				tickf_q <= 1'b1;
			end else if (wr && paddr == A_STAT && pwdata[B_TICK]) begin
				tickf_q <= 1'b0;
			end
			if (start_q && type_q == XT_CTRL) begin
				csent_q <= 1'b1;
			end else if (tick) begin
				csent_q <= 1'b0;
			end
			if (tick) begin
				scan_q <= '0;
			end else if (st_q == S_NEXT) begin
				scan_q <= epnum_q;
			end
			if (wr && paddr == A_WAIT) begin
				wait_q <= pwdata[15:0];
			end else if (tick && wait_q != '0) begin
				wait_q <= wait_q - 16'h0001;
			end
			if (wr && paddr == A_WDOG) begin
				wdog_q <= pwdata[15:0];
			end else if (tick && wdog_q != '0 && ctrl_busy && busy_q) begin
				wdog_q <= wdog_q - 16'h0001;
				// sticky: a later reload of the watchdog must not withdraw the request
				if (wdog_q == 16'h0001) begin
					sys_reset_req <= 1'b1;
				end
			end
			if (wr && paddr == A_POLL) begin
				pool_q <= pwdata[31:16];
			end else if (tick) begin
				pool_q <= pool_q + inc_q;
			end
		end
	end

	// transfer busy: raised by a token, dropped by error or completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else if (token_go) begin
			busy_q <= 1'b1;
		end else if ((st_q == S_IDLE && evt_req[EV_ERR]) || st_q == S_ACK) begin
			busy_q <= 1'b0;
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sofen_q <= 1'b0;
			forever_q <= 1'b0;
			type_q <= 2'b00;
			dirin_q <= 1'b0;
			epnum_q <= '0;
			start_q <= 1'b0;
			len_q <= '0;
			maxpkt_q <= RST_MAXPKT;
			inc_q <= RST_CREDIT_INC;
		end else begin
			start_q <= wr && paddr == A_CTRL && pwdata[B_START];
			if (wr && paddr == A_CTRL) begin
				sofen_q <= pwdata[B_SOFEN];
				forever_q <= pwdata[B_FOREVER];
				type_q <= pwdata[B_TYPE+:2];
				dirin_q <= pwdata[B_DIRIN];
				epnum_q <= pwdata[B_EPNUM+:4];
			end
			if (wr && paddr == A_REQ) begin
				len_q <= pwdata[15:0];
				maxpkt_q <= pwdata[B_MAXPKT+:11];
			end
			if (wr && paddr == A_POLL) begin
				inc_q <= pwdata[15:0];
			end
		end
	end

	// read data, captured during the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (rd_setup) begin
			case (paddr)
				A_CTRL: prdata_q <= {22'h0, 1'b0, epnum_q, dirin_q, type_q, forever_q, sofen_q};
				A_REQ: prdata_q <= {5'h00, maxpkt_q, len_q};
				A_STAT: prdata_q <= {6'h00, scan_q, failed_q, owned_q, hspend_q, csent_q,
					busy_q, tickf_q, fill_q};
				A_EP: prdata_q <= {naks_q, err_q, 6'h00, link_q, toggle_q};
				A_WAIT: prdata_q <= {16'h0000, wait_q};
				A_WDOG: prdata_q <= {16'h0000, wdog_q};
				A_POLL: prdata_q <= {pool_q, inc_q};
				A_FIFO: prdata_q <= {15'h0000, f_valid, f_data};
				default: prdata_q <= '0;
			endcase
		end
	end
endmodule

//--- bench/uht_seq_assertions.sv
// port assertions for the transfer sequencer
`timescale 1ns/1ns
module uht_chk
	import uht_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// events and issue
	input wire logic [uht_pkg::EV_W-1:0] evt_req,
	input wire logic [uht_pkg::EV_W-1:0] evt_clr,
	input wire logic token_go,
	input wire logic sys_reset_req
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_clr_only;
		|evt_clr |-> (evt_clr & ~evt_req) == '0;
	endproperty
	a_clr_only: assert property (p_clr_only) else $error("stray clear");
	property p_tick_clr;
		|evt_req[1:0] |-> evt_clr[1:0] == evt_req[1:0];
	endproperty
	a_tick_clr: assert property (p_tick_clr) else $error("tick not cleared");
	property p_ack_gap;
		evt_clr[3] |=> !evt_clr[3] [*2];
	endproperty
	a_ack_gap: assert property (p_ack_gap) else $error("ack too soon");
	property p_eval_quiet;
		evt_clr[3] |=> !token_go;
	endproperty
	a_eval_quiet: assert property (p_eval_quiet) else $error("token during eval");
	property p_err_quiet;
		evt_clr[2] |=> !token_go;
	endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("token after error");
	property p_wdog_hold;
		sys_reset_req |=> sys_reset_req;
	endproperty
	a_wdog_hold: assert property (p_wdog_hold) else $error("reset request dropped");
	property p_wdog_rise;
		$rose(sys_reset_req) |-> $past(|evt_req[1:0]);
	endproperty
	a_wdog_rise: assert property (p_wdog_rise) else $error("reset without tick");
	property p_apb;
		psel && penable |-> pready && pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h1C);
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer wrong");
endmodule
bind uht_seq uht_chk u_uht_chk (.*);

//--- bench/uht_dev_model.sv
// far-side model: transfer status, descriptors, completion and error events
`timescale 1ns/1ns
module uht_dev_model
	import uht_pkg::*;
(
	// clock
	input wire logic pclk,
	// error and completion requests, clear strobes
	output logic [1:0] dev_req,
	input wire logic [uht_pkg::EV_W-1:0] evt_clr,
	// status and descriptors
	output logic stat_dir_tx,
	output logic [3:0] stat_ep,
	output logic bd_tx_own,
	output logic [3:0] bd_tx_pid,
	output logic [10:0] bd_tx_cnt,
	output logic bd_rx_own,
	output logic [3:0] bd_rx_pid,
	output logic [10:0] bd_rx_cnt
);
	initial begin
		dev_req = 2'h0;
		{stat_dir_tx, stat_ep, bd_tx_pid, bd_rx_pid} = 13'h0;
		{bd_tx_own, bd_rx_own, bd_tx_cnt, bd_rx_cnt} = '1;
	end
	task automatic complete(input logic tx, input logic [3:0] e, input logic [3:0] p,
		input logic [10:0] c, input logic own);
		int n;
		n = 0;
		stat_dir_tx <= tx;
		stat_ep <= e;
		{bd_tx_own, bd_tx_pid, bd_tx_cnt} <= {tx ? own : 1'b1, tx ? p : ~p, c};
		{bd_rx_own, bd_rx_pid, bd_rx_cnt} <= {tx ? 1'b1 : own, tx ? ~p : p, c};
		dev_req[1] <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (evt_clr[EV_TRN] !== 1'b1 && n < 20);
		dev_req[1] <= 1'b0;
		// status may be rewritten once acknowledged
		{stat_dir_tx, stat_ep} <= {~tx, ~e};
		@(posedge pclk);
		{bd_tx_own, bd_tx_pid, bd_rx_own, bd_rx_pid} <= {1'b1, ~p, 1'b1, ~p};
	endtask
	task automatic bus_error();
		dev_req[0] <= 1'b1;
		@(posedge pclk);
		dev_req[0] <= 1'b0;
	endtask
endmodule

//--- bench/uht_seq_test.sv
// self-checking bench for the transfer sequencer
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, (e), (s)); end end
module uht_seq_test;
	import uht_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, ctrl_busy, rx_valid, rx_ready;
	logic pready, pslverr, serr, token_go, sys_reset_req;
	logic stat_dir_tx, bd_tx_own, bd_rx_own;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0] stat_ep, bd_tx_pid, bd_rx_pid, scan_ep, evt_clr, evt_req, ep;
	logic [10:0] bd_tx_cnt, bd_rx_cnt;
	logic [1:0] tick, dev_req;
	logic [15:0] rx_data;
	logic [31:0] seed = 32'hE12B;
	int err_count, num_checks, tok_n, fill, tog;
	int pk[3] = '{4, 4, 2};
	int lim[2] = '{3, 200};
	logic [15:0] fq[$];
	assign evt_req = {dev_req, tick};
	uht_seq u_uht_seq (.*);
	uht_dev_model u_uht_dev_model (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) if (token_go === 1'b1) tok_n++;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rdata = prdata;
		serr = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic pulse(input logic [1:0] v);
		@(posedge pclk);
		tick <= v;
		@(posedge pclk);
		tick <= 2'h0;
	endtask
	task automatic start(input logic [1:0] t, input logic i, input logic f, input int len);
		apb(1, A_REQ, {5'h0, 11'h004, len[15:0]});
		apb(1, A_EP, 0);
		{tok_n, fill, tog} = 0;
		apb(1, A_CTRL, {22'h0, 1'b1, ep, i, t, f, 1'b1});
		repeat (2) @(posedge pclk);
	endtask
	task automatic done(input logic tx, input logic [3:0] e, input logic [3:0] p,
		input int c, input logic own);
		u_uht_dev_model.complete(tx, e, p, c[10:0], own);
		repeat (2) @(posedge pclk);
	endtask
	task automatic chk(input int f, input logic ow, input logic fl, input int nk, input int er);
		apb(0, A_STAT, 0);
		`CHK("fill", f[15:0], rdata[15:0])
		`CHK("owned", ow, rdata[B_OWNED])
		`CHK("failed", fl, rdata[B_FAILED])
		apb(0, A_EP, 0);
		`CHK("toggle", tog[0], rdata[0])
		if (!fl) `CHK("link", ow, rdata[B_LINK])
		`CHK("naks", nk[15:0], rdata[31:16])
		`CHK("err", er[7:0], rdata[15:8])
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge pclk);
		err_count++;
		$display("MISMATCH watchdog exp done got timeout");
		test_done();
	end
	initial begin
		{presetn, psel, penable, pwrite, ctrl_busy, rx_valid, paddr, pwdata} = '0;
		{tick, rx_data, ep} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, A_POLL, 0);
		`CHK("credit_rst", RST_CREDIT_INC, rdata[15:0])
		apb(0, 8'h20, 0);
		`CHK("unmapped", 1'b1, serr)
		// fill the receive fifo past full while nobody drains it
		rx_valid <= 1'b1;
		rx_data <= 16'(rnd());
		repeat (20) begin
			@(posedge pclk);
			if (rx_ready === 1'b1) begin
				fq.push_back(rx_data);
				rx_data <= 16'(rnd());
			end
		end
		rx_valid <= 1'b0;
		`CHK("rx_count", 16, fq.size())
		while (fq.size() > 0) begin
			apb(0, A_FIFO, 0);
			`CHK("fifo", {1'b1, fq.pop_front()}, rdata[16:0])
		end
		apb(0, A_FIFO, 0);
		`CHK("fifo_empty", 1'b0, rdata[B_FVALID])
		apb(1, A_WAIT, 3);
		apb(1, A_POLL, 5);
		apb(1, A_CTRL, 1);
		pulse(2'h2);
		pulse(2'h1);
		apb(0, A_WAIT, 0);
		`CHK("wait", 2, rdata)
		apb(0, A_POLL, 0);
		`CHK("pool", 5, rdata[31:16])
		apb(0, A_STAT, 0);
		`CHK("tick", 1'b1, rdata[B_TICK])
		apb(1, A_CTRL, 0);
		pulse(2'h2);
		// frame event while frame generation is off must not count
		pulse(2'h1);
		apb(0, A_WAIT, 0);
		`CHK("wait_backup", 1, rdata)
		ep = 4'(rnd() % 15 + 1);
		start(XT_BULK, 1'b1, 1'b0, 10);
		done(1'b0, ~ep, PID_DATA0, 4, 1'b0);
		done(1'b0, ep, PID_DATA0, 4, 1'b1);
		`CHK("discard", 1, tok_n)
		foreach (pk[i]) begin
			done(1'b0, ep, tog ? PID_DATA1 : PID_DATA0, pk[i], 1'b0);
			fill += pk[i];
			tog ^= 1;
			`CHK("scan", ep, scan_ep)
		end
		`CHK("tokens", 4, tok_n)
		chk(fill, 1'b0, 1'b0, 0, 0);
		start(XT_CTRL, 1'b0, 1'b0, 0);
		pulse(2'h1);
		apb(0, A_STAT, 0);
		`CHK("ctrl_sent", 1'b0, rdata[B_CSENT])
		`CHK("rewind", 4'h0, scan_ep)
		done(1'b1, ep, PID_DATA0, 8, 1'b0);
		apb(0, A_STAT, 0);
		`CHK("hs_pend", 1'b1, rdata[B_HSPEND])
		done(1'b0, ep, PID_DATA1, 0, 1'b0);
		chk(8, 1'b0, 1'b0, 0, 0);
		foreach (lim[j]) begin
			start(j ? XT_CTRL : XT_INTR, 1'b0, 1'b0, 8);
			for (int k = 1; k <= lim[j] + 1; k++) begin
				done(1'b1, ep, PID_NAK, 0, 1'b0);
				if (k == lim[j]) chk(0, 1'b1, 1'b0, k, 0);
			end
			chk(0, 1'b0, 1'b1, lim[j] + 1, ERR_NAK_LIMIT);
		end
		start(XT_BULK, 1'b0, 1'b1, 8);
		repeat (5) done(1'b1, ep, PID_NAK, 0, 1'b0);
		chk(0, 1'b1, 1'b0, 0, 0);
		done(1'b1, ep, 4'h5, 0, 1'b0);
		chk(0, 1'b0, 1'b1, 0, {ERR_PID_TAG, 4'h5});
		start(XT_INTR, 1'b1, 1'b0, 8);
		done(1'b0, ep, PID_NAK, 0, 1'b0);
		chk(0, 1'b0, 1'b0, 1, 0);
		start(XT_BULK, 1'b0, 1'b0, 8);
		u_uht_dev_model.bus_error();
		repeat (2) @(posedge pclk);
		apb(0, A_STAT, 0);
		`CHK("busy", 1'b0, rdata[B_BUSY])
		`CHK("err_token", 1, tok_n)
		start(XT_BULK, 1'b0, 1'b0, 8);
		apb(1, A_WDOG, 2);
		ctrl_busy <= 1'b1;
		pulse(2'h1);
		// let the edge that acted on the tick settle before looking
		@(posedge pclk);
		`CHK("wdog_early", 1'b0, sys_reset_req)
		pulse(2'h1);
		@(posedge pclk);
		`CHK("wdog", 1'b1, sys_reset_req)
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		`CHK("reset", 1'b0, sys_reset_req)
		test_done();
	end
endmodule
